// ==== rtl/uel_regs.svh ====
// register offsets, field positions, reset values and timing of the usb
// event and link control block; assumes byte-wide registers on a plain port
`ifndef UEL_REGS_SVH
`define UEL_REGS_SVH
`define UEL_ADDR_W 3
`define UEL_OFF_STATUS 3'h0
`define UEL_OFF_MASK 3'h1
`define UEL_OFF_CONTROL 3'h2
`define UEL_OFF_ADDRESS 3'h3
`define UEL_OFF_XFER 3'h4
`define UEL_OFF_FAULT 3'h5
`define UEL_RST_STATUS 8'h00
`define UEL_RST_MASK 8'h00
`define UEL_RST_CONTROL 8'h06
`define UEL_RST_ADDRESS 8'h00
`define UEL_BIT_GOOD 7
`define UEL_BIT_SETUP_OVERRUN_FLAG 5
`define UEL_BIT_FAULT 4
`define UEL_BIT_SLEEP 3
`define UEL_BIT_WAKE 2
`define UEL_BIT_BUSRST 1
`define UEL_BIT_SOF 0
`define UEL_STATUS_SW_MASK 8'h3f
`define UEL_CTL_RW_MASK 8'h0f
`define UEL_MASK_RW_MASK 8'hbf
`define UEL_ADDR_MASK 8'h7f
`define UEL_FAULT_OTHER 3'h7
`define UEL_IDLE_NS 3000000
`define UEL_CLK_MHZ 250
`endif

// ==== rtl/uel_pkg.sv ====
// types for the usb event and link control block
package uel_pkg;
   typedef enum logic [1:0]
   {
      UEL_AWAKE = 2'b00,
      UEL_SLEEP = 2'b01,
      UEL_RESUMING = 2'b10
   } uel_power_t;

   // events from the serial engine, each a one-cycle pulse
   typedef struct packed
   {
      logic goodXfer;
      logic setupGood;
      logic faultSeen;
      logic [2:0] faultCode;
      logic sofSeen;
      logic busReset;
      logic busActive;
      logic resumeSeen;
      logic [1:0] tokenPid;
      logic epIn;
      logic [2:0] epNumber;
   } uel_event_t;

   typedef struct packed
   {
      logic [7:0] status;
      logic [7:0] mask;
      logic [7:0] control;
      logic [7:0] address;
      logic [7:0] xferStatus;
      logic [2:0] faultType;
      logic [7:0] readData;
      logic [31:0] idleCount;
      logic idleArmed;
      uel_power_t power;
      logic forceResetDly;
      logic busResetLine;
      logic busResetSync;
      logic idleLine;
      logic idleSync;
   } uel_state_t;
endpackage

// ==== rtl/usb_event_link.sv ====
// event flags, mask, link control, function address and transfer status of
// a full-speed usb function; serial engine events arrive as one-cycle pulses
// on the core clock, the idle and reset line levels come from the pins.
//
// Local design decisions: strobed register access and the register addresses.
`include "uel_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module usb_event_link
#(
   parameter int IDLE_CYCLES = (`UEL_IDLE_NS * `UEL_CLK_MHZ) / 1000 + 1
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [`UEL_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   input wire uel_pkg::uel_event_t linkEvent,
   input wire logic [6:0] endpointDoneFlags,
   input wire logic controlEndpointDone,
   input wire logic busIdlePin,
   input wire logic busResetPin,
   input wire logic cpuIntDisable,
   output logic interruptRequest,
   output logic wakeInterrupt,
   output logic endpointCtlReset,
   output logic linkHeldReset,
   output logic linkSuspended,
   output logic resumeDrive,
   output logic regulatorOff,
   output logic [6:0] functionAddress
);

   initial
   begin
      if (IDLE_CYCLES < 2)
         $error("IDLE_CYCLES must be at least 2");
      if (`UEL_ADDR_W < 3)
         $error("register index too narrow for six registers");
   end

   uel_pkg::uel_state_t stateReg;
   uel_pkg::uel_state_t stateNext;
   logic busReset;
   logic swClear;
   logic maskWrite;
   logic controlWrite;
   logic addressWrite;
   logic [7:0] pendingFlags;
   // the idle counter saturates at this limit
   localparam logic [31:0] IDLE_LIMIT = 32'(IDLE_CYCLES);

   function automatic logic [7:0] flagUpdate(input logic [7:0] cur,
      input logic [7:0] sets, input logic clr, input logic [7:0] wdata);
      logic [7:0] kept;
      begin
         kept = clr ? (cur & wdata) : cur;
         flagUpdate = kept | sets;
      end
   endfunction

   // one address decode serves every register write strobe
   function automatic logic regHit(input logic strobe,
      input logic [`UEL_ADDR_W-1:0] addr,
      input logic [`UEL_ADDR_W-1:0] offset);
      begin
         regHit = strobe && addr == offset;
      end
   endfunction

   //----------------------------------------------------------------
   // state update
   //----------------------------------------------------------------
   always_comb
   begin
      logic [7:0] sets;
      logic wakeEvent;
      sets = 8'h00;
      wakeEvent = 1'b0;
      stateNext = stateReg;
      // read data stand for one cycle only; idle reads return zero
      stateNext.readData = 8'h00;

      //-------------------------------------------------------------
      // pin synchronisers and register decode
      //-------------------------------------------------------------
      // pin levels pass two flops before use
      stateNext.busResetLine = busResetPin;
      stateNext.busResetSync = stateReg.busResetLine;
      stateNext.idleLine = busIdlePin;
      stateNext.idleSync = stateReg.idleLine;
      stateNext.forceResetDly = stateReg.control[0];
      // bus reset detect
      // a forced reset acts on the link like one seen on the bus, except for the bus reset flag and wake cause bit 6
      busReset = stateReg.busResetSync || stateReg.control[0];
      swClear = regHit(regWrite, regAddr, `UEL_OFF_STATUS);
      maskWrite = regHit(regWrite, regAddr, `UEL_OFF_MASK);
      controlWrite = regHit(regWrite, regAddr, `UEL_OFF_CONTROL);
      addressWrite = regHit(regWrite, regAddr, `UEL_OFF_ADDRESS);

      //-------------------------------------------------------------
      // transfer status
      //-------------------------------------------------------------
      // goodness judged by engine
      if (linkEvent.setupGood && controlEndpointDone)
         sets[`UEL_BIT_SETUP_OVERRUN_FLAG] = 1'b1;
      else if (linkEvent.goodXfer)
      begin
         stateNext.xferStatus = {linkEvent.tokenPid, linkEvent.epIn,
            2'b00, linkEvent.epNumber};
         // the direction bit belongs to endpoints 1 to 7 only
         if (linkEvent.epNumber == 3'h0)
            stateNext.xferStatus[5] = stateReg.xferStatus[5];
      end

      //-------------------------------------------------------------
      // error, frame and bus reset events
      //-------------------------------------------------------------
      // fault flag
      if (linkEvent.faultSeen)
      begin
         sets[`UEL_BIT_FAULT] = 1'b1;
      end
      sets[`UEL_BIT_SOF] = linkEvent.sofSeen;
      // flag on release of forced reset
      if (stateReg.busResetSync ||
         (stateReg.forceResetDly && !stateReg.control[0]))
         sets[`UEL_BIT_BUSRST] = 1'b1;

      //-------------------------------------------------------------
      // idle timer
      //-------------------------------------------------------------
      // idle timer
      // the count saturates so a long idle raises the flag only once
      if (!stateReg.idleSync || !stateReg.idleArmed || busReset)
         stateNext.idleCount = 32'h0;
      else if (stateReg.idleCount < IDLE_LIMIT)
         stateNext.idleCount = stateReg.idleCount + 32'h1;
      if (stateReg.idleArmed && stateReg.idleCount == IDLE_LIMIT - 32'h1
         && stateReg.idleSync)
         sets[`UEL_BIT_SLEEP] = 1'b1;


      //-------------------------------------------------------------
      // wake from sleep
      //-------------------------------------------------------------
      // wake on activity
      if (stateReg.power == uel_pkg::UEL_SLEEP &&
         (linkEvent.busActive || linkEvent.resumeSeen || busReset))
      begin
         wakeEvent = 1'b1;
         sets[`UEL_BIT_WAKE] = 1'b1;
      end


      //-------------------------------------------------------------
      // fault type
      //-------------------------------------------------------------
      // fault type cleared with flag
      if (swClear && !regWriteData[`UEL_BIT_FAULT])
         stateNext.faultType = 3'h0;
      if (linkEvent.faultSeen)
         stateNext.faultType = (linkEvent.faultCode == 3'h0) ?
            `UEL_FAULT_OTHER : linkEvent.faultCode;


      //-------------------------------------------------------------
      // event flags
      //-------------------------------------------------------------
      // software only clears
      stateNext.status = flagUpdate(stateReg.status, sets, swClear,
         regWriteData) & `UEL_STATUS_SW_MASK;
      // mirror of endpoint flags
      // mirrored each cycle, so a status write cannot clear it
      stateNext.status[`UEL_BIT_GOOD] = |endpointDoneFlags;

      //-------------------------------------------------------------
      // software registers
      //-------------------------------------------------------------
      if (maskWrite)
         stateNext.mask = regWriteData & `UEL_MASK_RW_MASK;
      if (controlWrite)
         stateNext.control[3:0] = regWriteData[3:0];
      if (addressWrite)
         stateNext.address = regWriteData & `UEL_ADDR_MASK;
      if (busReset)
         stateNext.address = 8'h00;


      //-------------------------------------------------------------
      // wake cause
      //-------------------------------------------------------------
      // wake cause bits
      if (linkEvent.resumeSeen)
         stateNext.control[7] = 1'b1;
      if (stateReg.busResetSync)
         stateNext.control[6] = 1'b1;
      // a wake in the same cycle as a control write keeps its cause
      if (controlWrite && !wakeEvent)
         stateNext.control[7:6] = 2'b00;

      //-------------------------------------------------------------
      // power sequence
      //-------------------------------------------------------------
      // idle check arming
      case (stateReg.power)
         uel_pkg::UEL_AWAKE:
         begin
            if (stateNext.control[1])
            begin
               stateNext.power = uel_pkg::UEL_SLEEP;
               stateNext.idleArmed = 1'b0;
            end
         end
         uel_pkg::UEL_SLEEP:
         begin
            if (wakeEvent)
            begin
               stateNext.control[1] = 1'b0;
               stateNext.power = uel_pkg::UEL_RESUMING;
            end
            // software leaving sleep on its own still passes resume
            else if (!stateNext.control[1])
               stateNext.power = uel_pkg::UEL_RESUMING;
         end
         uel_pkg::UEL_RESUMING:
         begin
            // resume ends once the bus is active again
            if (!stateReg.idleSync || busReset)
            begin
               stateNext.power = uel_pkg::UEL_AWAKE;
               stateNext.idleArmed = 1'b1;
            end
         end
         default:
            stateNext.power = uel_pkg::UEL_AWAKE;
      endcase
      // a reset seen in sleep is a wake event; arming waits for resume
      if (busReset && stateReg.power != uel_pkg::UEL_SLEEP)
         stateNext.idleArmed = 1'b1;
      stateNext.control[5:4] = 2'b00;


      //-------------------------------------------------------------
      // read port
      //-------------------------------------------------------------
      if (regRead)
      begin
         case (regAddr)
            `UEL_OFF_STATUS:
               stateNext.readData = stateReg.status;
            `UEL_OFF_MASK:
               stateNext.readData = stateReg.mask;
            `UEL_OFF_CONTROL:
               stateNext.readData = stateReg.control;
            `UEL_OFF_ADDRESS:
               stateNext.readData = stateReg.address;
            `UEL_OFF_XFER:
               stateNext.readData = stateReg.xferStatus;
            `UEL_OFF_FAULT:
               stateNext.readData = {5'h00, stateReg.faultType};
            default:
               stateNext.readData = 8'h00;
         endcase
      end
   end

   //----------------------------------------------------------------
   // state register
   //----------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      // system reset leaves the link asleep with the regulator off
      if (!reset_n)
      begin
         stateReg <= '0;
         stateReg.status <= `UEL_RST_STATUS;
         stateReg.mask <= `UEL_RST_MASK;
         stateReg.control <= `UEL_RST_CONTROL;
         stateReg.address <= `UEL_RST_ADDRESS;
         stateReg.power <= uel_pkg::UEL_SLEEP;
      end
      else
         stateReg <= stateNext;
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   assign regReadData = stateReg.readData;

   //----------------------------------------------------------------
   // interrupts
   //----------------------------------------------------------------
   // masked interrupt
   assign pendingFlags = stateReg.status & stateReg.mask;
   assign interruptRequest = |pendingFlags && !cpuIntDisable;
   assign wakeInterrupt = stateReg.status[`UEL_BIT_WAKE] &&
      stateReg.mask[`UEL_BIT_WAKE] && !cpuIntDisable;

   //----------------------------------------------------------------
   // link control lines
   //----------------------------------------------------------------
   // endpoint control clear
   assign endpointCtlReset = stateReg.busResetSync || stateReg.control[0];
   assign linkHeldReset = stateReg.control[0];
   assign linkSuspended = stateReg.power == uel_pkg::UEL_SLEEP;
   assign resumeDrive = stateReg.control[3];
   assign regulatorOff = stateReg.control[2];
   assign functionAddress = stateReg.address[6:0];

endmodule

`default_nettype wire

// ==== test/uel_link_sva.sv ====
// assertions on the ports of the usb event and link control block
// assumes a bind onto usb_event_link from the bench's top file
`include "uel_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module uel_link_sva
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [`UEL_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic cpuIntDisable,
   input wire logic interruptRequest,
   input wire logic wakeInterrupt,
   input wire logic endpointCtlReset,
   input wire logic linkHeldReset,
   input wire logic resumeDrive,
   input wire logic regulatorOff,
   input wire logic [6:0] functionAddress
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------
   // read port, interrupts, address and control lines
   // ------------------------------------------------
   chk_read_zero: assert property (
      !$past(regRead) || $past(regAddr) > `UEL_OFF_FAULT |-> !regReadData)
      else $error("read data not zero");
   chk_ctl_rsvd: assert property (
      $past(regRead) && $past(regAddr) == `UEL_OFF_CONTROL
      |-> regReadData[5:4] == 2'b00) else $error("control bits 5:4 set");
   chk_addr_bit7: assert property (
      $past(regRead) && $past(regAddr) == `UEL_OFF_ADDRESS
      |-> !regReadData[7]) else $error("address bit 7 set");
   chk_irq_gated: assert property (
      cpuIntDisable |-> !interruptRequest) else $error("irq while disabled");
   chk_wake_gated: assert property (
      cpuIntDisable |-> !wakeInterrupt) else $error("wake irq while disabled");
   chk_reset_addr: assert property (
      endpointCtlReset |=> functionAddress == 7'h00)
      else $error("address kept over reset");
   chk_held_reset: assert property (
      linkHeldReset |-> endpointCtlReset) else $error("held without reset");
   chk_addr_write: assert property (
      regWrite && regAddr == `UEL_OFF_ADDRESS && !endpointCtlReset
      |=> functionAddress == $past(regWriteData[6:0]))
      else $error("address write lost");
   chk_ctl_lines: assert property (
      regWrite && regAddr == `UEL_OFF_CONTROL
      |=> {resumeDrive, regulatorOff} == $past(regWriteData[3:2])
      && linkHeldReset == $past(regWriteData[0]))
      else $error("control lines wrong");
   chk_regoff_cause: assert property (
      $changed(regulatorOff) |-> $past(regWrite)
      && $past(regAddr) == `UEL_OFF_CONTROL)
      else $error("regulator moved alone");
endmodule
`default_nettype wire

// ==== test/uel_host_model.sv ====
// far side of the link: event pulses from the engine and bus pin levels
// assumes the bench calls its tasks and shares the core clock
`timescale 1ns/1ns
`default_nettype none
module uel_host_model
(
   input wire logic clock,
   output uel_pkg::uel_event_t linkEvent,
   output logic busIdlePin,
   output logic busResetPin
);
   initial
   begin
      linkEvent = '0;
      busIdlePin = 1'b0;
      busResetPin = 1'b0;
   end
   // drives one event word for a single cycle, then returns it to zero
   task automatic pulse(input uel_pkg::uel_event_t e);
      @(posedge clock) linkEvent <= e;
      @(posedge clock) linkEvent <= '0;
   endtask
   task automatic busReset(input int n);
      @(posedge clock) busResetPin <= 1'b1;
      repeat (n) @(posedge clock);
      busResetPin <= 1'b0;
   endtask
   task automatic idle(input logic v);
      @(posedge clock) busIdlePin <= v;
   endtask
endmodule
`default_nettype wire

// ==== test/usb_event_and_link_control_tb_top.sv ====
// register-level bench of the usb event and link control block
// assumes a short idle count so the sleep check fits the run
`include "uel_regs.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module usb_event_and_link_control_tb_top;
   logic clock = 1'b0, reset_n, regWrite, regRead;
   logic [`UEL_ADDR_W-1:0] regAddr;
   logic [7:0] regWriteData, regReadData;
   logic [6:0] endpointDoneFlags, functionAddress;
   logic controlEndpointDone, cpuIntDisable, busIdlePin;
   logic busResetPin, interruptRequest, wakeInterrupt, endpointCtlReset;
   logic linkHeldReset, linkSuspended, resumeDrive, regulatorOff;
   uel_pkg::uel_event_t linkEvent;
   int err_count = 0, checked = 0;
   always #2 clock = ~clock;
   uel_host_model u_uel_host_model (.clock(clock), .linkEvent(linkEvent),
      .busIdlePin(busIdlePin), .busResetPin(busResetPin));
   usb_event_link #(.IDLE_CYCLES(20)) u_usb_event_link (.clock(clock),
      .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
      .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
      .linkEvent(linkEvent), .endpointDoneFlags(endpointDoneFlags),
      .controlEndpointDone(controlEndpointDone), .busIdlePin(busIdlePin),
      .busResetPin(busResetPin), .cpuIntDisable(cpuIntDisable),
      .interruptRequest(interruptRequest), .wakeInterrupt(wakeInterrupt),
      .endpointCtlReset(endpointCtlReset), .linkHeldReset(linkHeldReset),
      .linkSuspended(linkSuspended), .resumeDrive(resumeDrive),
      .regulatorOff(regulatorOff), .functionAddress(functionAddress));
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock) {regWrite, regAddr, regWriteData} <= {1'b1, a, d};
      @(posedge clock) regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clock) {regRead, regAddr} <= {1'b1, a};
      @(posedge clock) regRead <= 1'b0;
      #1 `CHK(regReadData, e)
   endtask
   task automatic stop_test();
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // a hang costs a mismatch; the tests need about 1000 cycles
   initial
   begin
      #40000 err_count++;
      stop_test();
   end
   initial
   begin
      {reset_n, regWrite, regRead, regAddr, regWriteData} <= '0;
      {endpointDoneFlags, controlEndpointDone, cpuIntDisable} <= '0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      rd(`UEL_OFF_CONTROL, 8'h06);
      rd(`UEL_OFF_STATUS, 8'h00);
      rd(`UEL_OFF_MASK, 8'h00);
      rd(`UEL_OFF_XFER, 8'h00);
      rd(3'h6, 8'h00);
      wr(`UEL_OFF_CONTROL, 8'hf0);
      rd(`UEL_OFF_CONTROL, 8'h00);
      // regulator settle time, 3 us at 4 ns
      repeat (750) @(posedge clock);
      wr(`UEL_OFF_ADDRESS, 8'hff);
      rd(`UEL_OFF_ADDRESS, 8'h7f);
      u_uel_host_model.pulse(16'h0200);
      rd(`UEL_OFF_STATUS, 8'h01);
      wr(`UEL_OFF_MASK, 8'h01);
      rd(`UEL_OFF_MASK, 8'h01);
      `CHK(interruptRequest, 1'b1)
      @(posedge clock) cpuIntDisable <= 1'b1;
      #1 `CHK(interruptRequest, 1'b0)
      @(posedge clock) cpuIntDisable <= 1'b0;
      #1 `CHK(interruptRequest, 1'b1)
      // clear and new frame land on the same edge
      fork
         wr(`UEL_OFF_STATUS, 8'hfe);
         u_uel_host_model.pulse(16'h0200);
      join
      rd(`UEL_OFF_STATUS, 8'h01);
      wr(`UEL_OFF_STATUS, 8'hfe);
      wr(`UEL_OFF_STATUS, 8'hff);
      rd(`UEL_OFF_STATUS, 8'h00);
      for (int c = 0; c < 6; c++)
      begin
         u_uel_host_model.pulse({3'b001, 3'(c), 10'h000});
         rd(`UEL_OFF_FAULT, (c == 0) ? 8'h07 : 8'(c));
         rd(`UEL_OFF_STATUS, 8'h10);
         wr(`UEL_OFF_STATUS, 8'hef);
         rd(`UEL_OFF_FAULT, 8'h00);
      end
      @(posedge clock) endpointDoneFlags <= 7'h08;
      u_uel_host_model.pulse(16'h800b);
      rd(`UEL_OFF_XFER, 8'h23);
      wr(`UEL_OFF_STATUS, 8'h00);
      rd(`UEL_OFF_STATUS, 8'h80);
      u_uel_host_model.pulse(16'h8030);
      rd(`UEL_OFF_XFER, 8'he0);
      @(posedge clock) controlEndpointDone <= 1'b1;
      u_uel_host_model.pulse(16'hc020);
      rd(`UEL_OFF_STATUS, 8'ha0);
      rd(`UEL_OFF_XFER, 8'he0);
      @(posedge clock) {endpointDoneFlags, controlEndpointDone} <= '0;
      wr(`UEL_OFF_STATUS, 8'h00);
      rd(`UEL_OFF_STATUS, 8'h00);
      u_uel_host_model.busReset(8);
      rd(`UEL_OFF_STATUS, 8'h02);
      rd(`UEL_OFF_ADDRESS, 8'h00);
      wr(`UEL_OFF_STATUS, 8'h00);
      u_uel_host_model.idle(1'b1);
      repeat (30) @(posedge clock);
      rd(`UEL_OFF_STATUS, 8'h08);
      // enter sleep before clearing, so the idle check cannot refire
      wr(`UEL_OFF_CONTROL, 8'h02);
      wr(`UEL_OFF_STATUS, 8'h00);
      repeat (40) @(posedge clock);
      rd(`UEL_OFF_STATUS, 8'h00);
      wr(`UEL_OFF_MASK, 8'h04);
      u_uel_host_model.pulse(16'h0040);
      rd(`UEL_OFF_STATUS, 8'h04);
      `CHK(wakeInterrupt, 1'b1)
      `CHK(linkSuspended, 1'b0)
      rd(`UEL_OFF_CONTROL, 8'h80);
      u_uel_host_model.idle(1'b0);
      wr(`UEL_OFF_CONTROL, 8'h02);
      u_uel_host_model.busReset(8);
      rd(`UEL_OFF_CONTROL, 8'h40);
      wr(`UEL_OFF_ADDRESS, 8'h33);
      wr(`UEL_OFF_CONTROL, 8'h01);
      rd(`UEL_OFF_ADDRESS, 8'h00);
      wr(`UEL_OFF_STATUS, 8'h00);
      rd(`UEL_OFF_STATUS, 8'h00);
      wr(`UEL_OFF_CONTROL, 8'h00);
      rd(`UEL_OFF_STATUS, 8'h02);
      wr(`UEL_OFF_CONTROL, 8'h0c);
      rd(`UEL_OFF_CONTROL, 8'h0c);
      `CHK({resumeDrive, regulatorOff}, 2'b11)
      // a second system reset in mid-run returns the power-up state
      @(posedge clock) reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      #1 `CHK({linkSuspended, regulatorOff, linkHeldReset}, 3'b110)
      rd(`UEL_OFF_CONTROL, 8'h06);
      rd(`UEL_OFF_MASK, 8'h00);
      stop_test();
   end
endmodule
bind usb_event_link uel_link_sva u_uel_link_sva (.clock(clock),
   .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
   .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
   .cpuIntDisable(cpuIntDisable), .interruptRequest(interruptRequest),
   .wakeInterrupt(wakeInterrupt), .endpointCtlReset(endpointCtlReset),
   .linkHeldReset(linkHeldReset), .resumeDrive(resumeDrive),
   .regulatorOff(regulatorOff), .functionAddress(functionAddress));
`default_nettype wire
